/* File: design/uawb_pkg.sv */
// What this block does
// - Flag overflow before fifth rising edge.
// - Baud measurement counter is sixteen bits.
// - Counter keeps running after overflow.
// - Fifth edge sets receive flag, clears enable.
// - Reading receive data clears receive flag.
// - Overflow clear refused while enable set.
// - Sleep stops the baud counter.
// - Wake works only in asynchronous mode.
// - Wake enable suppresses reception, watches line.
// - Wake event is a falling edge.
// - Wake event raises receive flag at once.
// - Break-ending rising edge clears wake enable.
// - Non-zero character start counts as wake.
package uawb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int        ADDR_W    = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DIV  = 8'h08;
    localparam logic [7:0] OFF_RXD  = 8'h0C;
    localparam logic [7:0] OFF_IST  = 8'h10;
    localparam logic [7:0] OFF_IMSK = 8'h14;

    localparam int CTRL_AB_EN = 0;
    localparam int CTRL_WUE   = 1;
    localparam int CTRL_ASYNC = 2;
    localparam int CTRL_SLEEP = 3;
    localparam int STAT_OVF   = 0;
    localparam int STAT_RXIF  = 1;
    localparam int STAT_IDLE  = 2;
    localparam int EV_AB_DONE = 0;
    localparam int EV_OVF     = 1;
    localparam int EV_WAKE    = 2;
    localparam int EV_BRK_END = 3;

    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [2:0]  LAST_EDGE = 3'h4;
    localparam logic [15:0] DIV_RST   = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ABW  = 4'b0010,
        ST_ABC  = 4'b0100,
        ST_WKL  = 4'b1000
    } uawb_state_t;

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        rx_prev;
        uawb_state_t st;
        logic [15:0] cnt;
        logic [2:0]  edges;
        logic [15:0] div;
        logic        ab_en;
        logic        wake_on_break_enable;
        logic        async_en;
        logic        sleep;
        logic        ovf;
        logic        rxif;
        logic [3:0]  ist;
        logic [3:0]  imsk;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic [31:0] prdata;
    } uawb_regs_t;

endpackage

/* File: design/uawb_top.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module uawb_top
    import uawb_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              serial_receive_pin
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    uawb_regs_t s_ff;
    uawb_regs_t nxt_s;
    logic       rx_fall;
    logic       rx_rise;
    logic       access;
    logic       done;
    logic       mapped;

    // Exact match, so an unaligned address is refused like an unmapped one.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Edges are taken behind the second synchroniser stage, never from the raw pin.
    assign rx_fall = s_ff.rx_prev & ~s_ff.sync2;
    assign rx_rise = ~s_ff.rx_prev & s_ff.sync2;
    assign access  = psel & penable;
    assign done    = access & s_ff.pready;
    assign mapped  = hit(paddr, OFF_CTRL) | hit(paddr, OFF_STAT) | hit(paddr, OFF_DIV)
                   | hit(paddr, OFF_RXD) | hit(paddr, OFF_IST) | hit(paddr, OFF_IMSK);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Software writes are applied first and hardware events last, so an
    // event landing in the same cycle as a clear always survives.
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.sync1   = serial_receive_pin;
        nxt_s.sync2   = s_ff.sync1;
        nxt_s.rx_prev = s_ff.sync2;

        // One wait state: pready rises in the second access cycle.
        nxt_s.pready = access & ~s_ff.pready;
        if (access & ~s_ff.pready) begin
            nxt_s.pslverr = ~mapped;
            nxt_s.prdata  = 32'h0000_0000;
            if (hit(paddr, OFF_CTRL) && !pwrite) begin
                nxt_s.prdata[CTRL_AB_EN] = s_ff.ab_en;
                nxt_s.prdata[CTRL_WUE]   = s_ff.wake_on_break_enable;
                nxt_s.prdata[CTRL_ASYNC] = s_ff.async_en;
                nxt_s.prdata[CTRL_SLEEP] = s_ff.sleep;
            end
            if (hit(paddr, OFF_STAT) && !pwrite) begin
                nxt_s.prdata[STAT_OVF]  = s_ff.ovf;
                nxt_s.prdata[STAT_RXIF] = s_ff.rxif;
                nxt_s.prdata[STAT_IDLE] = (s_ff.st == ST_IDLE);
            end
            if (hit(paddr, OFF_DIV) && !pwrite) begin
                nxt_s.prdata[15:0] = s_ff.div;
            end
            if (hit(paddr, OFF_IST) && !pwrite) begin
                nxt_s.prdata[3:0] = s_ff.ist;
            end
            if (hit(paddr, OFF_IMSK) && !pwrite) begin
                nxt_s.prdata[3:0] = s_ff.imsk;
            end
        end else begin
            // Dropped outside the first access cycle, so it only ever stands beside pready.
            nxt_s.pslverr = 1'b0;
        end

        if (done && pwrite) begin
            if (hit(paddr, OFF_CTRL)) begin
                nxt_s.ab_en    = pwdata[CTRL_AB_EN];
                nxt_s.wake_on_break_enable      = pwdata[CTRL_WUE];
                nxt_s.async_en = pwdata[CTRL_ASYNC];
                nxt_s.sleep    = pwdata[CTRL_SLEEP];
            end
            // The overflow flag stays set against a clear while enable is on.
            if (hit(paddr, OFF_STAT) && pwdata[STAT_OVF] && !s_ff.ab_en) begin
                nxt_s.ovf = 1'b0;
            end
            if (hit(paddr, OFF_DIV)) begin
                nxt_s.div = pwdata[15:0];
            end
            if (hit(paddr, OFF_IST)) begin
                nxt_s.ist = s_ff.ist & ~pwdata[3:0];
            end
            if (hit(paddr, OFF_IMSK)) begin
                nxt_s.imsk = pwdata[3:0];
            end
        end
        if (done && !pwrite && hit(paddr, OFF_RXD)) begin
            nxt_s.rxif = 1'b0;
        end

        unique case (s_ff.st)
            ST_IDLE: begin
                // Wake-on-break keeps the receiver idle, in any processor mode.
                if (s_ff.wake_on_break_enable && s_ff.async_en) begin
                    if (rx_fall) begin
                        nxt_s.st              = ST_WKL;
                        nxt_s.rxif            = 1'b1;
                        nxt_s.ist[EV_WAKE]    = 1'b1;
                    end
                end else if (s_ff.ab_en && !s_ff.wake_on_break_enable) begin
                    nxt_s.st    = ST_ABW;
                    nxt_s.cnt   = 16'h0000;
                    nxt_s.edges = 3'h0;
                end
            end
            ST_ABW: begin
                if (!s_ff.ab_en || s_ff.wake_on_break_enable) begin
                    nxt_s.st = ST_IDLE;
                end else if (rx_fall) begin
                    // Counting starts on the start bit's falling edge, not on the enable write.
                    nxt_s.st = ST_ABC;
                end
            end
            ST_ABC: begin
                if (!s_ff.ab_en || s_ff.wake_on_break_enable) begin
                    nxt_s.st = ST_IDLE;
                end else begin
                    // Clocks are stopped in sleep, so the count freezes.
                    if (!s_ff.sleep) begin
                        nxt_s.cnt = s_ff.cnt + 16'h0001;
                        if (s_ff.cnt == CNT_MAX) begin
                            nxt_s.ovf         = 1'b1;
                            nxt_s.ist[EV_OVF] = 1'b1;
                        end
                    end
                    if (rx_rise) begin
                        // The edge count starts at zero, so the fifth edge finds it at LAST_EDGE.
                        nxt_s.edges = s_ff.edges + 3'h1;
                        if (s_ff.edges == LAST_EDGE) begin
                            nxt_s.st              = ST_IDLE;
                            nxt_s.ab_en           = 1'b0;
                            nxt_s.rxif            = 1'b1;
                            nxt_s.div             = s_ff.cnt;
                            nxt_s.ist[EV_AB_DONE] = 1'b1;
                        end
                    end
                end
            end
            ST_WKL: begin
                // The line stays low for the whole break; only its rising edge ends the wait.
                if (rx_rise) begin
                    nxt_s.st              = ST_IDLE;
                    nxt_s.wake_on_break_enable             = 1'b0;
                    nxt_s.ist[EV_BRK_END] = 1'b1;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase

        nxt_s.irq = |(nxt_s.ist & nxt_s.imsk);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // The synchroniser resets to line-idle high so no false edge appears.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff          <= '0;
            s_ff.sync1    <= 1'b1;
            s_ff.sync2    <= 1'b1;
            s_ff.rx_prev  <= 1'b1;
            s_ff.st       <= ST_IDLE;
            s_ff.div      <= DIV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata  = s_ff.prdata;
    assign pready  = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign irq     = s_ff.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ovf_set: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && !s_ff.sleep
        && (s_ff.cnt == CNT_MAX) |=> s_ff.ovf && (s_ff.cnt == 16'h0000))
        else $error("overflow flag not set on counter wrap");
    a_fifth_edge: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && rx_rise
        && (s_ff.edges == LAST_EDGE) |=> !s_ff.ab_en && s_ff.rxif && (s_ff.st == ST_IDLE))
        else $error("fifth edge did not finish measurement");
    a_div_load: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && rx_rise
        && (s_ff.edges == LAST_EDGE) |=> s_ff.div == $past(s_ff.cnt))
        else $error("divisor not loaded with count");
    a_ovf_hold: assert property (s_ff.ovf && s_ff.ab_en |=> s_ff.ovf)
        else $error("overflow flag cleared while enable set");
    a_sleep_freeze: assert property ((s_ff.st == ST_ABC) && s_ff.sleep && s_ff.ab_en
        && !s_ff.wake_on_break_enable |=> $stable(s_ff.cnt))
        else $error("counter moved in sleep");
    a_wake_int: assert property ((s_ff.st == ST_IDLE) && s_ff.wake_on_break_enable && s_ff.async_en && rx_fall
        |=> s_ff.rxif && (s_ff.st == ST_WKL))
        else $error("wake event missed");
    a_sync_only: assert property ((s_ff.st == ST_IDLE) && !s_ff.async_en |=> s_ff.st != ST_WKL)
        else $error("wake in synchronous mode");
    a_break_end: assert property ((s_ff.st == ST_WKL) && rx_rise |=> !s_ff.wake_on_break_enable && (s_ff.st == ST_IDLE))
        else $error("wake enable not cleared at break end");
    a_rd_clear: assert property (done && !pwrite && hit(paddr, OFF_RXD) && !rx_fall && !rx_rise
        |=> !s_ff.rxif)
        else $error("receive flag not cleared by data read");
    a_apb_wait: assert property (access && !s_ff.pready |=> s_ff.pready ##1 !s_ff.pready)
        else $error("pready not a single cycle after one wait");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("error flag outside the ready cycle");
    // A refused access still completes, so the master is never left waiting.
    a_bad_addr: assert property (access && !s_ff.pready && !mapped
        |=> pready && pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_div_write: assert property (done && pwrite && hit(paddr, OFF_DIV) && (s_ff.st != ST_ABC)
        |=> s_ff.div == $past(pwdata[15:0]))
        else $error("divisor write lost");
    // Software must see a true idle state before it arms the wake function.
    a_idle_flag: assert property (access && !s_ff.pready && !pwrite && hit(paddr, OFF_STAT)
        |=> prdata[STAT_IDLE] == $past(s_ff.st == ST_IDLE))
        else $error("idle flag does not follow the engine");

    // ------------------------------------------------------------
    // Measurement checks
    // ------------------------------------------------------------
    a_ab_start: assert property ((s_ff.st == ST_IDLE) && s_ff.ab_en && !s_ff.wake_on_break_enable
        |=> (s_ff.st == ST_ABW) && (s_ff.cnt == 16'h0000) && (s_ff.edges == 3'h0))
        else $error("measurement did not start from zero");
    // The count must not move before the start bit has begun.
    a_wait_start: assert property ((s_ff.st == ST_ABW) && s_ff.ab_en && !s_ff.wake_on_break_enable && rx_fall
        |=> (s_ff.st == ST_ABC) && (s_ff.cnt == 16'h0000))
        else $error("start bit did not begin the count");
    // The count keeps stepping through the wrap, so a long start bit still ends cleanly.
    a_cnt_run: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && !s_ff.sleep
        |=> s_ff.cnt == $past(s_ff.cnt) + 16'h0001)
        else $error("counter stalled while measuring");
    a_ovf_only: assert property (!s_ff.ovf && (s_ff.cnt != CNT_MAX) |=> !s_ff.ovf)
        else $error("overflow flag set without a counter wrap");
    a_ovf_event: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && !s_ff.sleep
        && (s_ff.cnt == CNT_MAX) |=> s_ff.ist[EV_OVF])
        else $error("overflow event not recorded");
    // Each rising edge but the last only advances the edge count.
    a_edge_step: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && rx_rise
        && (s_ff.edges != LAST_EDGE) |=> (s_ff.edges == $past(s_ff.edges) + 3'h1) && (s_ff.st == ST_ABC))
        else $error("rising edge not counted");
    a_ab_event: assert property ((s_ff.st == ST_ABC) && s_ff.ab_en && !s_ff.wake_on_break_enable && rx_rise
        && (s_ff.edges == LAST_EDGE) |=> s_ff.ist[EV_AB_DONE])
        else $error("measurement end not recorded");
    // Clearing the enable or setting the wake enable are the only ways out before the fifth edge.
    a_abort_idle: assert property (((s_ff.st == ST_ABW) || (s_ff.st == ST_ABC)) && !s_ff.ab_en
        |=> s_ff.st == ST_IDLE)
        else $error("cleared enable did not abort measurement");
    a_ovf_clear: assert property (done && pwrite && hit(paddr, OFF_STAT) && pwdata[STAT_OVF]
        && !s_ff.ab_en |=> !s_ff.ovf)
        else $error("overflow flag not cleared by software");
    // The receive flag survives everything except a completed data read.
    a_rxif_hold: assert property (s_ff.rxif && !(done && !pwrite && hit(paddr, OFF_RXD)) |=> s_ff.rxif)
        else $error("receive flag dropped without a data read");

    // ------------------------------------------------------------
    // Wake checks
    // ------------------------------------------------------------
    // While wake is armed the measurement engine must stay parked.
    a_wake_quiet: assert property (s_ff.wake_on_break_enable && ((s_ff.st == ST_IDLE) || (s_ff.st == ST_WKL))
        |=> (s_ff.st != ST_ABW) && (s_ff.st != ST_ABC))
        else $error("measurement started while wake enable set");
    a_wake_event: assert property ((s_ff.st == ST_IDLE) && s_ff.wake_on_break_enable && s_ff.async_en && rx_fall
        |=> s_ff.ist[EV_WAKE])
        else $error("wake event not recorded");
    // A mask write in the same cycle may legally hide the event, so it is left out.
    a_wake_irq: assert property ((s_ff.st == ST_IDLE) && s_ff.wake_on_break_enable && s_ff.async_en && rx_fall
        && s_ff.imsk[EV_WAKE] && !(done && pwrite && hit(paddr, OFF_IMSK)) |=> irq)
        else $error("wake event did not raise the interrupt");
    a_brk_event: assert property ((s_ff.st == ST_WKL) && rx_rise |=> s_ff.ist[EV_BRK_END])
        else $error("break end not recorded");
    // A low line of any length keeps the block waiting for the break to end.
    a_wkl_hold: assert property ((s_ff.st == ST_WKL) && !rx_rise |=> s_ff.st == ST_WKL)
        else $error("wake state left before the line rose");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_ab_done: cover property ((s_ff.st == ST_ABC) ##1 (s_ff.st == ST_IDLE) && s_ff.rxif);
    c_ovf: cover property (s_ff.ovf && (s_ff.st == ST_ABC));
    c_wake: cover property ((s_ff.st == ST_WKL) ##[1:1000] !s_ff.wake_on_break_enable);
    c_ovf_refused: cover property (s_ff.ovf && s_ff.ab_en && done && pwrite && hit(paddr, OFF_STAT));
    c_abort: cover property ((s_ff.st == ST_ABC) && !s_ff.ab_en);

endmodule

/* File: dv/uawb_node.sv */
`timescale 1ns/1ns
module uawb_node (
    input  wire logic pclk,
    output logic      serial_receive_pin
);
    // ------------------------------------------------------------
    // Remote serial node
    // ------------------------------------------------------------
    // The line idles high, as a released line with a pull-up does.
    initial serial_receive_pin = 1'b1;

    task automatic hold(input logic v, input int n);
        serial_receive_pin <= v;
        repeat (n) @(posedge pclk);
    endtask

    // Data 1010_1010 and the stop bit give five rising edges after the start bit.
    task automatic rest(input int bt);
        for (int i = 0; i < 9; i++) hold(~i[0], bt);
    endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
    import uawb_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rx, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    int          bad_count, samples_checked, cyc;

    uawb_top uawb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_receive_pin(rx));
    uawb_node uawb_node_i (.pclk(pclk), .serial_receive_pin(rx));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // The whole run is about 67000 cycles; a hang is cut at 80000.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask

    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    // Ready, read data and the error flag are all taken at the rising edge that ends the access.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {bad_count, samples_checked, cyc} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_DIV, 32'h0000_0000);
        chk("div_reset", r, 32'h0000_0000);
        apb(1'b1, OFF_DIV, 32'h0001_2345);
        apb(1'b0, OFF_DIV, 32'h0000_0000);
        chk("div_rw", r, 32'h0000_2345);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", r, 32'h0000_0000);
        // Plain measurement, then the same with the counter frozen by sleep.
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFF_CTRL, i ? 32'h0000_0009 : 32'h0000_0001);
            uawb_node_i.hold(1'b0, 20);
            uawb_node_i.rest(20);
            repeat (6) @(posedge pclk);
            apb(1'b0, OFF_DIV, 32'h0000_0000);
            chk("div", i ? r <= 12 : (r >= 168 && r <= 192), 1'b1);
            apb(1'b0, OFF_STAT, 32'h0000_0000);
            chk("rxif_set", r[STAT_RXIF], 1'b1);
            apb(1'b0, OFF_CTRL, 32'h0000_0000);
            chk("ab_en_clr", r[CTRL_AB_EN], 1'b0);
            apb(1'b0, OFF_RXD, 32'h0000_0000);
            apb(1'b0, OFF_STAT, 32'h0000_0000);
            chk("rxif_clr", r[STAT_RXIF], 1'b0);
        end
        // Abort in mid-measurement: enable cleared inside the start bit.
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        uawb_node_i.hold(1'b0, 20);
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        uawb_node_i.hold(1'b1, 20);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("abort_idle", r[STAT_IDLE:STAT_RXIF], 2'b10);
        // Start bit outlasts the 16-bit count; a clear is tried while enable is still set.
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        uawb_node_i.hold(1'b0, 65540);
        apb(1'b1, OFF_STAT, 32'h0000_0001);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("ovf_kept", r[STAT_OVF], 1'b1);
        uawb_node_i.rest(20);
        repeat (6) @(posedge pclk);
        apb(1'b0, OFF_DIV, 32'h0000_0000);
        chk("div_wrap", r >= 160 && r <= 192, 1'b1);
        apb(1'b0, OFF_IST, 32'h0000_0000);
        chk("ist_ab", r[1:0], 2'b11);
        apb(1'b1, OFF_STAT, 32'h0000_0001);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("ovf_clr", r[STAT_OVF], 1'b0);
        apb(1'b1, OFF_IST, 32'h0000_000F);
        apb(1'b0, OFF_RXD, 32'h0000_0000);
        // Wake without asynchronous mode must be ignored.
        apb(1'b1, OFF_CTRL, 32'h0000_0002);
        uawb_node_i.hold(1'b0, 260);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("wake_sync", r[STAT_RXIF], 1'b0);
        uawb_node_i.hold(1'b1, 40);
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk("wue_kept", r[CTRL_WUE], 1'b1);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("idle", r[STAT_IDLE], 1'b1);
        apb(1'b1, OFF_IMSK, 32'h0000_0004);
        apb(1'b1, OFF_CTRL, 32'h0000_000E);
        uawb_node_i.hold(1'b0, 260);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("wake_rxif", r[STAT_RXIF], 1'b1);
        chk("wake_irq", irq, 1'b1);
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk("wue_held", r[CTRL_WUE], 1'b1);
        uawb_node_i.hold(1'b1, 20);
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        chk("wue_clr", r[CTRL_WUE], 1'b0);
        apb(1'b0, OFF_IST, 32'h0000_0000);
        chk("ist_wake", r[3:2], 2'b11);
        apb(1'b1, OFF_IMSK, 32'h0000_0000);
        repeat (2) @(negedge pclk);
        chk("irq_masked", irq, 1'b0);
        apb(1'b0, OFF_RXD, 32'h0000_0000);
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk("wake_rxif_clr", r[STAT_RXIF], 1'b0);
        complete_run();
    end
endmodule
